// file: logic/hsl_hub_strap_latch_decoder.sv
// strap latch and decoder for the hub configuration straps
// assumes strap inputs and reset inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module hsl_hub_strap_latch_decoder
    import hsl_pkg::*;
(
    // clock and system (power-on) reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // external chip reset, active low
    input  wire logic                 chipRst_n,
    // strap levels as sensed at the pins
    input  wire hsl_straps_type       strapIn,
    // decoded configuration
    output logic                      bridgingMasterSetting,
    output logic                      configSlaveSetting,
    output logic [NUM_PORTS-1:0]      posLineDisabled,
    output logic [NUM_PORTS-1:0]      negLineDisabled,
    output logic [NUM_PORTS-1:0]      usb2PortDisabled,
    output logic [NUM_PORTS-1:0]      usb3PortDisabled,
    output logic                      hubInReset,
    output logic                      strapsValid
);

    ////////////////////////////////////////////////////////////////////
    // reset tracking

    logic           inReset;
    logic           releaseNow;
    logic           rstSeen_reg;
    hsl_straps_type latch_reg;
    logic           valid_reg;

    // either reset holds the hub; chip reset low means reset
    assign inReset    = sys_rst | ~chipRst_n; // RL11
    // capture in the first cycle with neither reset active after any reset period, por included
    assign releaseNow = rstSeen_reg & ~inReset; // RL2

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rstSeen_reg <= 1'b1;
        end else begin
            rstSeen_reg <= ~chipRst_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // latch: straps only matter at the end of reset, pins are free after

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_reg <= STRAPS_RESET;
            valid_reg <= 1'b0;
        end else if (!chipRst_n) begin
            valid_reg <= 1'b0;
        end else if (releaseNow) begin // RL1 RL12
            latch_reg <= strapIn; // RL2
            valid_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode

    wire logic                 masterNext;
    wire logic                 slaveNext;
    wire logic [NUM_PORTS-1:0] portOffNext;

    // reserved mode levels fall through to neither mode
    assign masterNext = valid_reg
                      & (latch_reg.modeLevel == MODE_PD200K); // RL3 RL5
    assign slaveNext  = valid_reg
                      & (latch_reg.modeLevel == MODE_PU200K); // RL4 RL5
    // a port is off only with both line straps set
    assign portOffNext = latch_reg.portPosLineDisableStrap
                       & latch_reg.portNegLineDisableStrap; // RL9

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bridgingMasterSetting <= 1'b0;
            configSlaveSetting    <= 1'b0;
            posLineDisabled       <= PORTS_NONE;
            negLineDisabled       <= PORTS_NONE;
            usb2PortDisabled      <= PORTS_NONE;
            usb3PortDisabled      <= PORTS_NONE;
            hubInReset            <= 1'b1;
            strapsValid           <= 1'b0;
        end else begin
            bridgingMasterSetting <= masterNext;
            configSlaveSetting    <= slaveNext;
            posLineDisabled       <=
                latch_reg.portPosLineDisableStrap; // RL6 RL7
            negLineDisabled       <=
                latch_reg.portNegLineDisableStrap; // RL6 RL8
            usb2PortDisabled      <= portOffNext;
            usb3PortDisabled      <= portOffNext; // RL10
            hubInReset            <= inReset;
            strapsValid           <= valid_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_release;
        !chipRst_n ##1 chipRst_n;
    endsequence

    property p_capture;
        @(posedge clk) disable iff (sys_rst)
        s_release |=> (latch_reg == $past(strapIn));
    endproperty
    a_capture: assert property (p_capture) // RL2
        else $error("strap not captured at reset release");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        (chipRst_n && $past(chipRst_n) && valid_reg) |=> $stable(latch_reg);
    endproperty
    a_hold: assert property (p_hold) // RL12
        else $error("latched straps changed outside reset");

    property p_ignore;
        @(posedge clk) disable iff (sys_rst)
        (chipRst_n && !rstSeen_reg && strapIn != latch_reg)
            |=> $stable(latch_reg);
    endproperty
    a_ignore: assert property (p_ignore) // RL1
        else $error("strap pins sampled outside reset");

    property p_master;
        @(posedge clk) disable iff (sys_rst)
        (valid_reg && latch_reg.modeLevel == MODE_PD200K)
            |=> bridgingMasterSetting && !configSlaveSetting;
    endproperty
    a_master: assert property (p_master) // RL3
        else $error("bridging master mode not selected");

    property p_slave;
        @(posedge clk) disable iff (sys_rst)
        (valid_reg && latch_reg.modeLevel == MODE_PU200K)
            |=> configSlaveSetting && !bridgingMasterSetting;
    endproperty
    a_slave: assert property (p_slave) // RL4
        else $error("config slave mode not selected");

    property p_reserved;
        @(posedge clk) disable iff (sys_rst)
        (latch_reg.modeLevel != MODE_PD200K
            && latch_reg.modeLevel != MODE_PU200K)
            |=> !bridgingMasterSetting && !configSlaveSetting;
    endproperty
    a_reserved: assert property (p_reserved) // RL5
        else $error("reserved mode level enabled a mode");

    property p_lines;
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> posLineDisabled == $past(latch_reg.portPosLineDisableStrap)
             && negLineDisabled == $past(latch_reg.portNegLineDisableStrap);
    endproperty
    a_lines: assert property (p_lines) // RL7 RL8
        else $error("line disable outputs do not follow latch");

    property p_port_pair;
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> usb3PortDisabled == usb2PortDisabled
             && usb2PortDisabled == (posLineDisabled & negLineDisabled);
    endproperty
    a_port_pair: assert property (p_port_pair) // RL10
        else $error("usb3 port disable does not track usb2");

    property p_reset_out;
        @(posedge clk) disable iff (sys_rst)
        !chipRst_n |=> hubInReset ##1 !strapsValid;
    endproperty
    a_reset_out: assert property (p_reset_out) // RL11
        else $error("chip reset not reflected");

    ////////////////////////////////////////////////////////////////////
    // further checks on the reset walk and on holding the decode

    // sys_rst must be seen high in the start cycle, so no disable here;
    // a fresh sys_rst after the capture cannot alter the sampled latch
    sequence s_por_release;
        sys_rst ##1 (!sys_rst && chipRst_n);
    endsequence

    property p_por_capture;
        @(posedge clk)
        s_por_release |=> (latch_reg == $past(strapIn)) && valid_reg;
    endproperty
    a_por_capture: assert property (p_por_capture) // RL2
        else $error("strap not captured at power-on release");

    property p_valid_rise;
        @(posedge clk) disable iff (sys_rst)
        s_release |=> ##1 strapsValid;
    endproperty
    a_valid_rise: assert property (p_valid_rise) // RL11
        else $error("valid flag missing after chip reset release");

    property p_reset_clear;
        @(posedge clk) disable iff (sys_rst)
        chipRst_n |=> !hubInReset;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // RL11
        else $error("hub reset output stuck after release");

    // no mode may be offered before a capture has been taken
    property p_no_mode;
        @(posedge clk) disable iff (sys_rst)
        !valid_reg |=> !bridgingMasterSetting && !configSlaveSetting;
    endproperty
    a_no_mode: assert property (p_no_mode) // RL1
        else $error("mode enabled without a captured strap");

    // two quiet cycles: latch and decode registers have both settled
    sequence s_settled;
        (!inReset && !releaseNow) [*2];
    endsequence

    property p_out_hold;
        @(posedge clk) disable iff (sys_rst)
        s_settled |=> $stable(bridgingMasterSetting)
            && $stable(configSlaveSetting)
            && $stable(posLineDisabled)
            && $stable(negLineDisabled)
            && $stable(usb2PortDisabled)
            && $stable(usb3PortDisabled);
    endproperty
    a_out_hold: assert property (p_out_hold) // RL12
        else $error("decoded outputs moved outside reset");

endmodule // hsl_hub_strap_latch_decoder

`default_nettype wire

// file: logic/hsl_pkg.sv
// constants and carrier types for the hub strap latch decoder
// assumes strap levels arrive already resolved by the analog sensing
//
// Operation
// RL1 - straps set default configuration only while a reset is active
// RL2 - each strap is captured into its latch when reset deasserts
// RL3 - weak pull-down mode level selects management master for i2c bridging
// RL4 - weak pull-up mode level selects management slave for hub configuration
// RL5 - the four other mode levels are reserved and enable neither mode
// RL6 - one positive and one negative disable strap per downstream port 1-6
// RL7 - positive-line strap 0 enables D+, 1 disables D+
// RL8 - negative-line strap 0 enables D-, 1 disables D-
// RL9 - board holds both straps high to disable a port
// RL10 - a strap-disabled usb 2.0 port also disables its usb 3.2 port
// RL11 - low external reset resets hub; latch on por and its rising edge
// RL12 - latched values hold until a later reset is released again
package hsl_pkg;
    localparam int NUM_PORTS = 6;
    localparam int MODE_W    = 3;

    // decoded level of the multi-level mode strap
    localparam logic [MODE_W-1:0] MODE_PD200K = 3'h0;
    localparam logic [MODE_W-1:0] MODE_PU200K = 3'h1;

    localparam logic [NUM_PORTS-1:0] PORTS_NONE = 6'h00;

    typedef struct packed {
        logic [MODE_W-1:0]    modeLevel;
        logic [NUM_PORTS-1:0] portPosLineDisableStrap;
        logic [NUM_PORTS-1:0] portNegLineDisableStrap;
    } hsl_straps_type;

    localparam hsl_straps_type STRAPS_RESET = '{
        modeLevel: MODE_PD200K,
        portPosLineDisableStrap: PORTS_NONE,
        portNegLineDisableStrap: PORTS_NONE
    };
endpackage

// file: tb/hsl_strap_board.sv
// board straps and reset-side pin model
// assumes the bench says when the straps must be held
`timescale 1ns/1ps
`default_nettype none
module hsl_strap_board
    import hsl_pkg::*;
(
    // control from the bench
    input  wire logic           clk,
    input  wire logic           holdStraps,
    input  wire hsl_straps_type strapVal,
    // pins as the device sees them
    output var  hsl_straps_type strapIn
);
    hsl_straps_type otherUse_reg;
    // outside reset the pins carry other traffic, so they never sit still
    always_ff @(posedge clk) otherUse_reg <= ~strapIn;
    assign strapIn = holdStraps ? strapVal : otherUse_reg;
endmodule // hsl_strap_board
`default_nettype wire

// file: tb/test_hub_strap_latch_decoder.sv
// self-checking bench for the strap latch decoder
// assumes the board model drives the strap pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin samplesChecked++; if ((g) !== (e)) begin nFail++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module test_hub_strap_latch_decoder;
    import hsl_pkg::*;
    logic clk, sys_rst, chipRst_n, holdStraps, bm, cs, hr, sv;
    logic [NUM_PORTS-1:0] pd, nd, u2, u3;
    hsl_straps_type strapVal, strapIn;
    int nFail, samplesChecked;
    logic [31:0] seed;
    hsl_strap_board u_board (.clk(clk), .holdStraps(holdStraps),
        .strapVal(strapVal), .strapIn(strapIn));
    hsl_hub_strap_latch_decoder u_dut (.clk(clk), .sys_rst(sys_rst),
        .chipRst_n(chipRst_n), .strapIn(strapIn),
        .bridgingMasterSetting(bm), .configSlaveSetting(cs),
        .posLineDisabled(pd), .negLineDisabled(nd), .usb2PortDisabled(u2),
        .usb3PortDisabled(u3), .hubInReset(hr), .strapsValid(sv));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nextRand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [NUM_PORTS-1:0] expOff(hsl_straps_type s);
        return s.portPosLineDisableStrap & s.portNegLineDisableStrap;
    endfunction
    task automatic checkOut(hsl_straps_type s);
        `CHK("master", s.modeLevel == MODE_PD200K, bm)
        `CHK("slave", s.modeLevel == MODE_PU200K, cs)
        `CHK("dplus", s.portPosLineDisableStrap, pd)
        `CHK("dminus", s.portNegLineDisableStrap, nd)
        `CHK("usb2", expOff(s), u2)
        `CHK("usb3", expOff(s), u3)
        `CHK("valid", 1'b1, sv)
        `CHK("inreset", 1'b0, hr)
    endtask
    // one reset of either kind, straps held across the capture edge
    task automatic capture(logic useChip, hsl_straps_type v);
        @(negedge clk);
        if (useChip) chipRst_n = 1'b0;
        else sys_rst = 1'b1;
        holdStraps = 1'b1;
        strapVal = v;
        repeat (4) @(negedge clk);
        `CHK("inreset", 1'b1, hr)
        `CHK("valid", 1'b0, sv)
        `CHK("master", 1'b0, bm)
        sys_rst = 1'b0;
        chipRst_n = 1'b1;
        @(negedge clk);
        holdStraps = 1'b0;
        @(negedge clk);
        checkOut(v);
        repeat (3) @(negedge clk);
        checkOut(v);
        $display("test done chip=%0d straps=%h", useChip, v);
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        nFail++;
        conclude();
    end
    initial begin
        hsl_straps_type v;
        logic [31:0]    r;
        sys_rst = 1'b1;
        chipRst_n = 1'b1;
        holdStraps = 1'b1;
        strapVal = STRAPS_RESET;
        nFail = 0;
        samplesChecked = 0;
        seed = 32'h00000034;
        for (int i = 0; i < 24; i++) begin
            r = nextRand();
            v = r[$bits(hsl_straps_type)-1:0];
            v.modeLevel = i[2:0];
            if (i == 8) v = {3'h1, 12'hFFF};
            if (i == 9) v = {3'h0, 12'hFC0};
            // both reset kinds meet every mode level, master and slave too
            capture(i[0] ^ i[4], v);
        end
        conclude();
    end
endmodule // test_hub_strap_latch_decoder
`default_nettype wire
